// ===== src/zsx_defines.svh
// Constants shared by the zero stuffing expander and the down converter model.
`ifndef ZSX_DEFINES_SVH
`define ZSX_DEFINES_SVH
`define ZSX_DW 16
`define ZSX_ACCW 48
`define ZSX_RW 16
`define ZSX_LW 8
`define ZSX_R_MIN 16'h0010
`define ZSX_R_MAX 16'h8000
`define ZSX_FIR_QUAD 3'h4
`define ZSX_FIR_REAL 3'h2
`define ZSX_L_ONE 8'h01
`define ZSX_LO_QTR 2'h1
`define ZSX_CLK_MHZ 100
`define ZSX_CLK_MAX_MHZ 75
`define ZSX_SCALE_FRAC 15
`define ZSX_TAPS 4
`endif

// ===== src/zsx_pkg.sv
// Types shared by the converter model and its checker.
package zsx_pkg;
   typedef enum logic [1:0] {
      ZSX_FMT_QUAD = 2'b01,
      ZSX_FMT_REAL = 2'b10
   } zsx_fmt_t;
endpackage : zsx_pkg

// ===== src/zsx_expander.sv
// Zero stuffing sample rate expander with a modulo-L counter.
`timescale 1ns/10ps
`include "zsx_defines.svh"
module zsx_expander (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic [`ZSX_LW-1:0] expand_l,
   input wire logic in_strobe,
   input wire logic [`ZSX_DW-1:0] in_data,
   output logic [`ZSX_DW-1:0] out_data,
   output logic out_valid
);
   logic [`ZSX_LW-1:0] cnt_q;
   logic [`ZSX_DW-1:0] hold_q;
   logic pend_q;
   logic term;

   // ----------------------------------------------------------------
   // Counter phase
   // ----------------------------------------------------------------
   // A strobe restarts the count, so the sample always lands on the terminal slot.
   assign term = (cnt_q == '0);
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         cnt_q <= '0;
      end else if (in_strobe) begin
         cnt_q <= '0;
      end else if (cnt_q + `ZSX_L_ONE >= expand_l) begin
         cnt_q <= '0;
      end else begin
         cnt_q <= cnt_q + `ZSX_L_ONE;
      end
   end

   // Sample capture; one real sample is gated per L cycles, the rest are zeros.
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         hold_q <= '0;
         pend_q <= 1'b0;
      end else if (in_strobe) begin
         hold_q <= in_data;
         pend_q <= 1'b1;
      end else if (term) begin
         pend_q <= 1'b0;
      end
   end

   // AND gating of the data bits by the terminal state.
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         out_data <= '0;
         out_valid <= 1'b0;
      end else begin
         out_data <= hold_q & {`ZSX_DW{term & pend_q}};
         out_valid <= 1'b1;
      end
   end
endmodule : zsx_expander

// ===== src/zsx_ddc.sv
// Expander followed by a modelled down converter chain.
// Overview of operation
// - High decimation factor accepted from 16 up to 32768.
// - Quadrature format makes the FIR stage decimate by four.
// - Real format makes the FIR stage decimate by two.
// - Real mode shifts the last scaled word of each FIR window by quarter output rate and sums them.
// - In-phase and quadrature oscillators differ by a quarter cycle.
// - Expander emits L-1 zero samples after every real sample.
// - Modulo-L counter terminal state gates input bits through AND logic.
// - Scaling multiplier sits between high decimation stage and FIR.
// - Filtering after zero insertion applies overall gain of L.
// - Minimum quadrature decimation without expander is sixteen times four.
// - Minimum real decimation without expander is sixteen times two.
// - All logic runs from one converter clock.
`timescale 1ns/10ps
`include "zsx_defines.svh"
module zsx_ddc (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic [`ZSX_LW-1:0] expand_l,
   input wire logic [`ZSX_RW:0] hdf_rate,
   input wire logic [`ZSX_DW-1:0] scale_factor,
   input wire zsx_pkg::zsx_fmt_t out_format,
   input wire logic in_strobe,
   input wire logic [`ZSX_DW-1:0] in_data,
   output logic [`ZSX_DW-1:0] out_i,
   output logic [`ZSX_DW-1:0] out_q,
   output logic out_valid,
   output logic [`ZSX_RW+3:0] total_decimation
);
   logic [`ZSX_DW-1:0] x_data;
   logic x_valid;
   logic [1:0] lo_phase_q;
   logic signed [`ZSX_DW-1:0] mix_i, mix_q;
   logic signed [`ZSX_ACCW-1:0] acc_i_q, acc_q_q;
   logic [`ZSX_RW:0] rate_eff, hdf_cnt_q;
   logic hdf_dump;
   logic signed [`ZSX_DW-1:0] sc_i_q, sc_q_q;
   logic sc_v_q;
   logic signed [`ZSX_DW+1:0] fir_i_q, fir_q_q;
   logic [2:0] fir_cnt_q, fir_dec;
   logic [1:0] wv_q;
   logic fir_last;

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   // Saturating conversion keeps overflow from wrapping into sign errors.
   function automatic logic signed [`ZSX_DW-1:0] sat(input logic signed [`ZSX_ACCW-1:0] v);
      logic signed [`ZSX_ACCW-1:0] mx;
      mx = (`ZSX_ACCW'(1) <<< (`ZSX_DW-1)) - `ZSX_ACCW'(1);
      if (v > mx) sat = mx[`ZSX_DW-1:0];
      else if (v < -mx - `ZSX_ACCW'(1)) sat = ~mx[`ZSX_DW-1:0];
      else sat = v[`ZSX_DW-1:0];
   endfunction : sat

   // Quarter-rate sinusoid sample: +1, 0, -1, 0 for phases 0..3.
   function automatic logic signed [`ZSX_DW-1:0] lo_mul(input logic [1:0] ph,
         input logic signed [`ZSX_DW-1:0] d);
      case (ph)
         2'd0: lo_mul = d;
         2'd2: lo_mul = -d;
         default: lo_mul = '0;
      endcase
   endfunction : lo_mul

   // ----------------------------------------------------------------
   // Expander
   // ----------------------------------------------------------------
   zsx_expander u_exp (
      .ref_clk(ref_clk),
      .rst(rst),
      .expand_l(expand_l),
      .in_strobe(in_strobe),
      .in_data(in_data),
      .out_data(x_data),
      .out_valid(x_valid)
   );

   // ----------------------------------------------------------------
   // Local oscillator and mixer
   // ----------------------------------------------------------------
   // Single free running clock domain; the source rate follows from it.
   always_ff @(posedge ref_clk) begin
      if (rst) lo_phase_q <= '0;
      else lo_phase_q <= lo_phase_q + 2'd1;
   end
   assign mix_i = lo_mul(lo_phase_q, x_data);
   assign mix_q = lo_mul(lo_phase_q + `ZSX_LO_QTR, x_data);

   // ----------------------------------------------------------------
   // High decimation stage
   // ----------------------------------------------------------------
   // Out of range factors are clamped into the supported span.
   always_comb begin
      if (hdf_rate < {1'b0, `ZSX_R_MIN}) rate_eff = {1'b0, `ZSX_R_MIN};
      else if (hdf_rate > {1'b0, `ZSX_R_MAX}) rate_eff = {1'b0, `ZSX_R_MAX};
      else rate_eff = hdf_rate;
   end
   assign hdf_dump = x_valid && (hdf_cnt_q + 17'd1 >= rate_eff);

   // Dump counter; a lowered factor ends the open window at the next sample.
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         hdf_cnt_q <= '0;
      end else if (hdf_dump) begin
         hdf_cnt_q <= '0;
      end else if (x_valid) begin
         hdf_cnt_q <= hdf_cnt_q + 17'd1;
      end
   end

   // Integrate and dump; a cheap stand-in for the multi-stage comb design.
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         acc_i_q <= '0;
         acc_q_q <= '0;
      end else if (hdf_dump) begin
         acc_i_q <= `ZSX_ACCW'(mix_i);
         acc_q_q <= `ZSX_ACCW'(mix_q);
      end else if (x_valid) begin
         acc_i_q <= acc_i_q + `ZSX_ACCW'(mix_i);
         acc_q_q <= acc_q_q + `ZSX_ACCW'(mix_q);
      end
   end

   // ----------------------------------------------------------------
   // Scaling multiplier
   // ----------------------------------------------------------------
   // The scale factor carries 1/R; a second multiply by expand_l applies the gain of L after zero stuffing.
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         sc_i_q <= '0;
         sc_q_q <= '0;
         sc_v_q <= 1'b0;
      end else begin
         sc_v_q <= hdf_dump;
         if (hdf_dump) begin
            sc_i_q <= sat((acc_i_q * $signed({1'b0, scale_factor}) *
               $signed({1'b0, expand_l})) >>> `ZSX_SCALE_FRAC);
            sc_q_q <= sat((acc_q_q * $signed({1'b0, scale_factor}) *
               $signed({1'b0, expand_l})) >>> `ZSX_SCALE_FRAC);
         end
      end
   end

   // ----------------------------------------------------------------
   // Fixed FIR stage
   // ----------------------------------------------------------------
   assign fir_dec = (out_format == zsx_pkg::ZSX_FMT_REAL) ? `ZSX_FIR_REAL : `ZSX_FIR_QUAD;

   // A lowered factor closes the open window at the next sample instead of running past it.
   assign fir_last = sc_v_q && (fir_cnt_q + 3'd1 >= fir_dec);

   // Window counter over the scaled samples.
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         fir_cnt_q <= '0;
      end else if (fir_last) begin
         fir_cnt_q <= '0;
      end else if (sc_v_q) begin
         fir_cnt_q <= fir_cnt_q + 3'd1;
      end
   end

   // Boxcar accumulators; each window starts empty after its word is handed on.
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         fir_i_q <= '0;
         fir_q_q <= '0;
      end else if (fir_last) begin
         fir_i_q <= '0;
         fir_q_q <= '0;
      end else if (sc_v_q) begin
         fir_i_q <= fir_i_q + sc_i_q;
         fir_q_q <= fir_q_q + sc_q_q;
      end
   end

   // Phase of the quarter output rate shift, stepped once per output word.
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         wv_q <= '0;
      end else if (fir_last) begin
         wv_q <= wv_q + 2'd1;
      end
   end

   // Output words stand until the next window closes; the strobe lasts one cycle.
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         out_i <= '0;
         out_q <= '0;
         out_valid <= 1'b0;
      end else begin
         out_valid <= fir_last;
         if (fir_last && out_format == zsx_pkg::ZSX_FMT_REAL) begin
            // Quarter output rate shift of both paths, summed into one real stream.
            out_i <= sat(`ZSX_ACCW'(lo_mul(wv_q, sc_i_q))
               - `ZSX_ACCW'(lo_mul(wv_q + `ZSX_LO_QTR, sc_q_q)));
            out_q <= '0;
         end else if (fir_last) begin
            // The boxcar sum is divided by its length of four to keep unity gain.
            out_i <= sat(`ZSX_ACCW'(fir_i_q + sc_i_q) >>> 2);
            out_q <= sat(`ZSX_ACCW'(fir_q_q + sc_q_q) >>> 2);
         end
      end
   end

   // ----------------------------------------------------------------
   // Aggregate decimation report
   // ----------------------------------------------------------------
   // Minimum without expansion is 64 quadrature, 32 real; L divides it down.
   always_ff @(posedge ref_clk) begin
      if (rst) total_decimation <= '0;
      else total_decimation <= (20'(rate_eff) * 20'(fir_dec)) /
         20'((expand_l == '0) ? `ZSX_L_ONE : expand_l);
   end
endmodule : zsx_ddc

// ===== sim/zsx_ddc_sva.sv
// Concurrent checks on the ports of the expander and converter chain.
`timescale 1ns/10ps
`include "zsx_defines.svh"
module zsx_ddc_chk (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic [`ZSX_LW-1:0] expand_l,
   input wire logic [`ZSX_RW:0] hdf_rate,
   input wire logic [`ZSX_DW-1:0] scale_factor,
   input wire zsx_pkg::zsx_fmt_t out_format,
   input wire logic in_strobe,
   input wire logic [`ZSX_DW-1:0] in_data,
   input wire logic [`ZSX_DW-1:0] out_i,
   input wire logic [`ZSX_DW-1:0] out_q,
   input wire logic out_valid,
   input wire logic [`ZSX_RW+3:0] total_decimation
);
   logic [`ZSX_RW+3:0] td_exp;
   logic [`ZSX_RW+3:0] r_eff;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   // ------------------------------------------------------------
   // Expected decimation and checks
   // ------------------------------------------------------------
   // The rate is clamped first, so an out of range request still gives a legal figure.
   always_comb begin
      r_eff = 20'(hdf_rate);
      if (hdf_rate < `ZSX_R_MIN) r_eff = 20'(`ZSX_R_MIN);
      if (hdf_rate > `ZSX_R_MAX) r_eff = 20'(`ZSX_R_MAX);
      td_exp = r_eff * ((out_format == zsx_pkg::ZSX_FMT_REAL) ? 20'h0_0002 : 20'h0_0004);
      if (expand_l > `ZSX_L_ONE) td_exp = td_exp / 20'(expand_l);
   end
   sequence cfg_held;
      ($stable(hdf_rate) && $stable(expand_l) && $stable(out_format))[*3];
   endsequence
   a_rst_quiet: assert property (disable iff (1'b0) rst |=>
      !out_valid && out_i == 0 && out_q == 0 && total_decimation == 0)
      else $error("outputs not cleared by reset");
   a_valid_single: assert property (out_valid |=> !out_valid[*8])
      else $error("output strobe too close");
   a_real_qzero: assert property (out_valid && $past(out_format) == zsx_pkg::ZSX_FMT_REAL |->
      out_q == 0) else $error("quadrature word not zero in real mode");
   a_out_hold: assert property (!out_valid |-> ##1
      (out_valid || ($stable(out_i) && $stable(out_q)))) else $error("output moved between strobes");
   a_quad_total: assert property (cfg_held ##0 out_format == zsx_pkg::ZSX_FMT_QUAD |->
      total_decimation == td_exp) else $error("wrong quadrature total decimation");
   a_real_total: assert property (cfg_held ##0 out_format == zsx_pkg::ZSX_FMT_REAL |->
      total_decimation == td_exp) else $error("wrong real total decimation");
   a_rate_clamp: assert property (cfg_held ##0 (hdf_rate < `ZSX_R_MIN ||
      hdf_rate > `ZSX_R_MAX) |-> total_decimation == td_exp) else $error("rate not clamped");
   a_expand_div: assert property (cfg_held ##0 expand_l > `ZSX_L_ONE |->
      total_decimation == td_exp) else $error("total not divided by expansion");
endmodule : zsx_ddc_chk

// ===== sim/zsx_src.sv
// Sampled data source that feeds the expander.
`timescale 1ns/10ps
module zsx_src (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic [7:0] gap,
   output logic in_strobe,
   output logic [15:0] in_data
);
   logic [7:0] cnt_q;
   logic [15:0] smp_q;
   // One strobe every gap cycles keeps the source at or below clock over L.
   always_ff @(posedge ref_clk) begin
      if (rst || cnt_q + 8'h01 >= gap) begin
         cnt_q <= 8'h00;
      end else begin
         cnt_q <= cnt_q + 8'h01;
      end
      if (rst) begin
         smp_q <= 16'h1234;
      end else if (in_strobe) begin
         smp_q <= smp_q + 16'h0321;
      end
   end
   // Between strobes the data is inverted so a stale word is never mistaken for a new one.
   assign in_strobe = !rst && cnt_q == 8'h00;
   assign in_data = in_strobe ? smp_q : ~smp_q;
endmodule : zsx_src

// ===== sim/testbench.sv
// Self-checking bench for the expander and converter chain.
`timescale 1ns/10ps
`include "zsx_defines.svh"
module testbench;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] expand_l = 8'h01;
   logic [16:0] hdf_rate = 17'h0_0010;
   logic [15:0] scale_factor = 16'h8000;
   zsx_pkg::zsx_fmt_t out_format = zsx_pkg::ZSX_FMT_QUAD;
   logic [7:0] gap = 8'h01;
   logic in_strobe;
   logic [15:0] in_data, out_i, out_q;
   logic out_valid;
   logic [19:0] total_decimation;
   int num_errors = 0;
   int compares = 0;
   always #5 ref_clk = ~ref_clk;
   zsx_src zsx_src_inst (.ref_clk, .rst, .gap, .in_strobe, .in_data);
   zsx_ddc zsx_ddc_inst (.ref_clk, .rst, .expand_l, .hdf_rate, .scale_factor, .out_format,
      .in_strobe, .in_data, .out_i, .out_q, .out_valid, .total_decimation);
   // ------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------
   task automatic check(input string what, input logic [19:0] exp, input logic [19:0] got);
      compares++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask : check
   task automatic give_verdict();
      if (num_errors == 0 && compares > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : give_verdict
   task automatic set_cfg(input logic [16:0] r, input logic [7:0] l, input logic q,
      input logic [7:0] g);
      @(posedge ref_clk);
      hdf_rate <= r;
      expand_l <= l;
      out_format <= q ? zsx_pkg::ZSX_FMT_QUAD : zsx_pkg::ZSX_FMT_REAL;
      gap <= g;
   endtask : set_cfg
   // Counts cycles up to the next output strobe; after 3000 cycles without one it fails an out_valid check.
   task automatic wait_valid(output int n);
      n = 0;
      do begin
         @(posedge ref_clk);
         #1;
         n++;
      end while (out_valid !== 1'b1 && n < 3000);
      if (out_valid !== 1'b1) check("out_valid", 20'h0_0001, 20'(out_valid));
   endtask : wait_valid
   // Expected totals are clamped rate times FIR factor over L.
   task automatic t_total(input logic [16:0] r, input logic [7:0] l, input logic q);
      logic [19:0] e;
      e = (r < 17'h0_0010) ? 20'h0_0010 : (r > 17'h0_8000) ? 20'h0_8000 : 20'(r);
      e = e * (q ? 20'h0_0004 : 20'h0_0002) / ((l > 8'h01) ? 20'(l) : 20'h0_0001);
      set_cfg(r, l, q, (l > 8'h01) ? l : 8'h01);
      // Four edges hold the setting long enough for the checker to judge it as well.
      repeat (4) @(posedge ref_clk);
      #1;
      check("total_decimation", e, total_decimation);
   endtask : t_total
   // Steady output period, measured after the chain has settled.
   task automatic t_period(input logic [16:0] r, input logic [7:0] l, input logic q);
      int n;
      set_cfg(r, l, q, l);
      wait_valid(n);
      wait_valid(n);
      wait_valid(n);
      check("period", 20'(r) * (q ? 20'h0_0004 : 20'h0_0002), 20'(n));
      if (!q) check("real out_q", 20'h0_0000, 20'(out_q));
   endtask : t_period
   // With L a multiple of four every kept sample meets the same oscillator phase,
   // so the stuffed zeros leave exactly one of the two paths silent.
   task automatic t_iq_split();
      int n;
      set_cfg(17'h0_0010, 8'h10, 1'b1, 8'h10);
      repeat (3) wait_valid(n);
      check("one silent path", 20'h0_0001, 20'((out_i == '0) ^ (out_q == '0)));
   endtask : t_iq_split
   // A zero scale factor must silence both outputs once the old windows have drained.
   task automatic t_scale_zero();
      int n;
      @(posedge ref_clk);
      scale_factor <= 16'h0000;
      repeat (3) wait_valid(n);
      check("scaled out_i", 20'h0_0000, 20'(out_i));
      check("scaled out_q", 20'h0_0000, 20'(out_q));
      @(posedge ref_clk);
      scale_factor <= 16'h8000;
   endtask : t_scale_zero
   initial begin
      repeat (10) @(posedge ref_clk);
      check("reset outputs", 20'h0_0000, {out_valid, out_i | out_q} | total_decimation);
      rst <= 1'b0;
      t_total(17'h0_000f, 8'h01, 1'b1);
      t_total(17'h1_0000, 8'h00, 1'b0);
      t_total(17'h0_0201, 8'h08, 1'b1);
      t_total(17'h0_0010, 8'h04, 1'b0);
      t_period(17'h0_0010, 8'h01, 1'b1);
      t_period(17'h0_0010, 8'h01, 1'b0);
      t_period(17'h0_0010, 8'h08, 1'b1);
      t_iq_split();
      t_scale_zero();
      give_verdict();
   end
   // The whole run needs under a thousand cycles of the 50000 allowed, so this only catches hangs.
   initial begin
      #500000;
      num_errors++;
      give_verdict();
   end
endmodule : testbench
bind zsx_ddc zsx_ddc_chk zsx_ddc_chk_inst (.ref_clk, .rst, .expand_l, .hdf_rate, .scale_factor,
   .out_format, .in_strobe, .in_data, .out_i, .out_q, .out_valid, .total_decimation);
